// *** src/asr_defs.vh ***
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

`define ASR_ADDR_W 8
`define ASR_DATA_W 16
`define ASR_ADDR_RESET 8'h00
`define ASR_ADDR_PDN 8'h0f
`define ASR_ADDR_STATUS 8'h80
`define ASR_RESET_BIT 0
`define ASR_CH_LSB 0
`define ASR_CH_MSB 7
`define ASR_LIGHT_BIT 8
`define ASR_DEEP_BIT 9
`define ASR_PINSEL_BIT 10
`define ASR_PDN_MASK 16'h07ff
`define ASR_PDN_RESET 16'h0000
`define ASR_PWR_NORMAL 2'h0
`define ASR_PWR_PARTIAL 2'h1
`define ASR_PWR_COMPLETE 2'h2
`define ASR_WARM_US 50
`define ASR_CLK_MHZ 40

`endif

// *** src/asr_ctrl.v ***
// Function
// R1: Writing reset bit restores all registers
// R2: Reset bit clears itself afterwards
// R3: Eight channel sleep bits at 7:0
// R4: Channel bit N sleeps channel N only
// R5: Light sleep bit gives partial power-down
// R6: Deep sleep bit gives complete power-down
// R7: Host keeps clock 50 us before wake
// R8: Global modes via register and pin
// R9: Pin select 0: pin gives complete
// R10: Pin select 1: pin gives partial
// R11: Power-down inactive after reset
// R12: Host writes unused bits as zero
// R13: Host writes all functions at once
// R14: Complete beats partial beats normal
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.vh"

module asr_ctrl (
  input wire i_clk,
  input wire i_arst_n,
  input wire [`ASR_ADDR_W-1:0] i_addr,
  input wire [`ASR_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_sleep_pin,
  output reg [`ASR_DATA_W-1:0] o_rdata,
  output reg [7:0] o_channel_sleep,
  output reg [1:0] o_power_state,
  output reg o_soft_reset_busy,
  output reg o_warm_ok
);

  localparam [15:0] WARM_CYCLES = `ASR_WARM_US * `ASR_CLK_MHZ;

  // Three-stage sampler for the asynchronous pin
  reg [2:0] pin_sync_q;
  reg pin_lvl_q;
  reg [15:0] pdn_q;
  reg rst_pend_q;
  reg [15:0] warm_cnt_q;
  reg [1:0] state_d;
  reg pin_req_d;

  function [1:0] pick_state;
    input deep;
    input light;
    begin
      if (deep)
        pick_state = `ASR_PWR_COMPLETE;
      else if (light)
        pick_state = `ASR_PWR_PARTIAL;
      else
        pick_state = `ASR_PWR_NORMAL;
    end
  endfunction

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_sync_q <= 3'h0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_sleep_pin};
      // Level only moves once stages two and three agree
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_lvl_q <= pin_sync_q[2];
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pdn_q <= `ASR_PDN_RESET; // [R11]
      rst_pend_q <= 1'b0;
    end else if (rst_pend_q) begin
      // Reset takes one cycle; writes in that cycle are dropped
      pdn_q <= `ASR_PDN_RESET; // [R1]
      rst_pend_q <= 1'b0; // [R2]
    end else if (i_wr && i_addr == `ASR_ADDR_RESET) begin
      rst_pend_q <= i_wdata[`ASR_RESET_BIT]; // [R1]
    end else if (i_wr && i_addr == `ASR_ADDR_PDN) begin
      // Whole word at once; unused bits are not stored
      pdn_q <= i_wdata & `ASR_PDN_MASK; // [R3] [R13]
    end
  end

  always @* begin
    if (pdn_q[`ASR_PINSEL_BIT])
      pin_req_d = 1'b0;
    else
      pin_req_d = pin_lvl_q; // [R9]
    state_d = pick_state(pdn_q[`ASR_DEEP_BIT] | pin_req_d, // [R6] [R8] [R14]
      pdn_q[`ASR_LIGHT_BIT] | (pin_lvl_q & pdn_q[`ASR_PINSEL_BIT])); // [R5] [R10]
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_channel_sleep <= 8'h00;
      o_power_state <= `ASR_PWR_NORMAL;
      o_soft_reset_busy <= 1'b0;
      warm_cnt_q <= 16'h0000;
      o_warm_ok <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_channel_sleep <= pdn_q[`ASR_CH_MSB:`ASR_CH_LSB]; // [R4]
      o_power_state <= state_d;
      o_soft_reset_busy <= rst_pend_q;
      // Clock has run long enough in partial sleep for a quick wake
      if (o_power_state != `ASR_PWR_PARTIAL)
        warm_cnt_q <= 16'h0000;
      else if (warm_cnt_q != WARM_CYCLES)
        warm_cnt_q <= warm_cnt_q + 16'h0001;
      o_warm_ok <= (o_power_state == `ASR_PWR_PARTIAL) &&
        (warm_cnt_q == WARM_CYCLES); // [R7]
      if (i_rd) begin
        case (i_addr)
          `ASR_ADDR_RESET: o_rdata <= {15'h0000, rst_pend_q};
          `ASR_ADDR_PDN: o_rdata <= pdn_q;
          `ASR_ADDR_STATUS: o_rdata <= {12'h000, o_warm_ok, pin_lvl_q, state_d};
          default: o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

endmodule // asr_ctrl
`default_nettype wire

// *** bench/asr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_host (
  input wire logic i_clk,
  input wire logic i_req,
  output var logic o_sleep_pin = 1'b0
);
  // Pin only moves after an edge, like a host flop
  always @(posedge i_clk) o_sleep_pin <= i_req;
endmodule // asr_host
`default_nettype wire

// *** bench/asr_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_sleep_pin,
  input wire logic [7:0] o_channel_sleep,
  input wire logic [1:0] o_power_state,
  input wire logic o_soft_reset_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence wr_pd; i_wr && i_addr == 8'h0f; endsequence
  sequence wr_rst; i_wr && i_addr == 8'h00 && i_wdata[0]; endsequence
  sequence pin_lo; !i_sleep_pin [*8]; endsequence
  ch_set_a: assert property (wr_pd |-> ##2 o_channel_sleep == $past(i_wdata[7:0], 2))
    else $error("chan");
  ch_hold_a: assert property (!i_wr [*3] |=> $stable(o_channel_sleep)) else $error("hold");
  deep_a: assert property (wr_pd ##0 i_wdata[9] |-> ##2 o_power_state == 2'h2)
    else $error("deep");
  light_a: assert property (pin_lo ##0 wr_pd ##0 i_wdata[9:8] == 2'h1
    |-> ##2 o_power_state == 2'h1) else $error("light");
  idle_a: assert property (pin_lo ##0 wr_pd ##0 i_wdata[9:8] == 2'h0
    |-> ##2 o_power_state == 2'h0) else $error("idle");
  pin_a: assert property (i_sleep_pin [*8] |=> o_power_state != 2'h0) else $error("pin");
  busy_a: assert property (wr_rst |-> ##2 o_soft_reset_busy ##1 !o_soft_reset_busy)
    else $error("busy");
  rst_a: assert property (wr_rst |-> ##3 o_channel_sleep == 8'h00) else $error("rst");
endmodule // asr_ctrl_props
bind asr_ctrl asr_ctrl_props asr_ctrl_props_inst (.i_clk, .i_arst_n, .i_addr, .i_wdata,
  .i_wr, .i_sleep_pin, .o_channel_sleep, .o_power_state, .o_soft_reset_busy);
`default_nettype wire

// *** bench/asr_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_test;
  logic i_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, req = 0, sp;
  logic [7:0] i_addr = 0, cs;
  logic [15:0] i_wdata = 0, rd;
  logic [1:0] ps;
  int mismatches = 0, tests_run = 0;
  always #12.5 i_clk = ~i_clk;
  asr_ctrl asr_ctrl_inst (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sleep_pin(sp),
    .o_rdata(rd), .o_channel_sleep(cs), .o_power_state(ps), .o_soft_reset_busy(), .o_warm_ok());
  asr_host asr_host_inst (.i_clk, .i_req(req), .o_sleep_pin(sp));
  task chk(logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // Strobes are launched on an edge and dropped on the next one
  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1;
    @(posedge i_clk);
    i_wr <= 0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // Read data stands only in the cycle after the strobe, then returns to zero
  task rdc(logic [7:0] a, logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_clk);
    i_rd <= 0;
    #1 chk(rd, e);
    @(posedge i_clk);
    #1 chk(rd, 16'h0000);
  endtask
  task pin(logic v, logic [1:0] e);
    @(posedge i_clk);
    req <= v;
    repeat (10) @(posedge i_clk);
    #1 chk({14'h0, ps}, {14'h0, e});
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    // About 2100 cycles of tests, with a wide margin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1;
    @(posedge i_clk) #1;
    rdc(8'h0f, 16'h0000);
    wr(8'h0f, 16'h00a5);
    chk({8'h0, cs}, 16'h00a5);
    wr(8'h0f, 16'h0100);
    chk({14'h0, ps}, 16'h0001);
    wr(8'h0f, 16'h0300);
    chk({14'h0, ps}, 16'h0002);
    wr(8'h00, 16'h0001);
    rdc(8'h0f, 16'h0000);
    rdc(8'h00, 16'h0000);
    pin(1, 2'h2);
    wr(8'h0f, 16'h0400);
    chk({14'h0, ps}, 16'h0001);
    repeat (2010) @(posedge i_clk);
    #1;
    rdc(8'h80, 16'h000d);
    pin(0, 2'h0);
    print_verdict;
  end
endmodule // asr_ctrl_test
`default_nettype wire
